// ### rtl/crl_pkg.sv
package crl_pkg;
  // panel sampling depth and line terminal count
  localparam int          SYNC_STAGES      = 2;
  localparam int          NUM_TERMINALS    = 4;
  // load channel encodings
  localparam logic [1:0]  CHAN_MUX         = 2'h0;
  localparam logic [1:0]  CHAN_SEL1        = 2'h1;
  localparam logic [1:0]  CHAN_SEL2        = 2'h2;
  localparam logic [1:0]  CHAN_BAD         = 2'h3;
  localparam logic [1:0]  COND_CODE_BAD    = 2'h3;
  localparam logic [1:0]  COND_CODE_OK     = 2'h0;
  // status byte with unusual end (unit exception) bit
  localparam int          UNIT_EXC_BIT     = 0;
  localparam logic [7:0]  STATUS_EXC_BYTE  = 8'h01;
  // register map offsets
  localparam logic [3:0]  OFF_CTRL         = 4'h0;
  localparam logic [3:0]  OFF_STATUS       = 4'h4;
  localparam logic [3:0]  OFF_LOAD         = 4'h8;
  localparam logic [3:0]  OFF_TERM         = 4'hC;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
  localparam logic [31:0] TERM_RESET       = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
  // control register bit positions (write one for a pulse)
  localparam int          CB_MUX_CLR       = 0;
  localparam int          CB_SEL1_CLR      = 1;
  localparam int          CB_SEL2_CLR      = 2;
  localparam int          CB_SYS_RST       = 3;
  localparam int          CB_LOAD          = 4;
  localparam int          CB_RUN           = 5;
  localparam int          CB_STOP          = 6;
  localparam int          CB_STOR_CLR      = 7;
  localparam int          NUM_ACTIONS      = 8;

  typedef enum logic [1:0] {
    CRL_IDLE    = 2'b00,
    CRL_RUNNING = 2'b01,
    CRL_STOPPING = 2'b10
  } crl_run_t;
endpackage

// ### rtl/crl_pulse_if.sv
`timescale 1ns/100ps
`default_nettype none
interface crl_pulse_if #(parameter int N = 8);
  logic [N-1:0] level;
  logic [N-1:0] pulse;
  modport src (output level, input pulse);
  modport det (input level, output pulse);
endinterface
`default_nettype wire

// ### rtl/crl_edge_pulse.sv
`timescale 1ns/100ps
`default_nettype none
// synchronise momentary controls and emit one pulse per press
module crl_edge_pulse #(
  parameter int N = 8
) (
  input  wire logic   aclk,
  input  wire logic   aresetn,
  crl_pulse_if.det    pif
);
  import crl_pkg::*;
  logic [N-1:0] meta_q;
  logic [N-1:0] sync_q;
  logic [N-1:0] last_q;
  logic [N-1:0] pulse_q;
  wire  [N-1:0] rise_w = sync_q & ~last_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q  <= '0;
      sync_q  <= '0;
      last_q  <= '0;
      pulse_q <= '0;
    end else begin
      meta_q  <= pif.level;
      sync_q  <= meta_q;
      last_q  <= sync_q;
      pulse_q <= rise_w;
    end
  end
  assign pif.pulse = pulse_q;
endmodule
`default_nettype wire

// ### rtl/crl_console.sv
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module crl_console #(
  parameter int NT = crl_pkg::NUM_TERMINALS
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // panel momentary switches
  input  wire logic          mux_channel_clear_switch,
  input  wire logic          first_selector_clear_switch,
  input  wire logic          second_selector_clear_switch,
  input  wire logic          system_reset_switch,
  input  wire logic          load_switch,
  input  wire logic          run_switch,
  input  wire logic          stop_switch,
  input  wire logic          storage_clear_switch,
  // panel levels
  input  wire logic          switch_enable,
  input  wire logic          power_fault_indicate,
  input  wire logic          power_fault_off,
  input  wire logic          power_applied,
  input  wire logic          power_seq_done,
  input  wire logic          instruction_hold_control,
  input  wire logic [1:0]    load_channel_sw,
  input  wire logic [3:0]    load_control_unit_sw,
  input  wire logic [3:0]    load_device_sw,
  input  wire logic          sel1_installed,
  input  wire logic          sel2_installed,
  // processor side
  input  wire logic          instr_boundary,
  input  wire logic          function_load,
  input  wire logic [7:0]    function_next,
  input  wire logic          address_load,
  input  wire logic [15:0]   address_next,
  output logic               mux_channel_reset,
  output logic               sel1_channel_reset,
  output logic               sel2_channel_reset,
  output logic               system_clear,
  output logic               storage_control_reset,
  output logic               load_start,
  output logic [1:0]         load_channel,
  output logic [3:0]         load_control_unit,
  output logic [3:0]         load_device,
  output logic [1:0]         condition_code,
  output logic               processor_running,
  output logic               io_enable,
  output logic [7:0]         function_register,
  output logic [15:0]        storage_address_register,
  output logic               system_power_lamp,
  output logic               test_mode_lamp,
  // line terminals
  input  wire logic [NT-1:0] term_in_req,
  input  wire logic [NT-1:0] term_out_req,
  input  wire logic [NT-1:0] term_half_duplex,
  input  wire logic [NT-1:0] term_in_inhibit,
  input  wire logic [NT-1:0] term_out_inhibit,
  input  wire logic [NT-1:0] term_in_cmd,
  input  wire logic [NT-1:0] term_out_cmd,
  output logic [NT-1:0]      term_in_active,
  output logic [NT-1:0]      term_out_active,
  output logic [2*NT-1:0]    term_grant,
  output logic [NT-1:0]      term_in_status_valid,
  output logic [NT-1:0]      term_out_status_valid,
  output logic [7:0]         term_status_byte,
  output logic               dialer_enable,
  // AXI4-Lite slave
  input  wire logic [3:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [3:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready
);
  import crl_pkg::*;

  // ---------------- bus slave ----------------
  logic                   aw_q;
  logic                   w_q;
  logic [3:0]             awaddr_q;
  logic [31:0]            wdata_q;
  logic                   wstrb0_q;
  logic                   bvalid_q;
  logic [1:0]             bresp_q;
  logic                   rvalid_q;
  logic [31:0]            rdata_q;
  logic [1:0]             rresp_q;
  logic [NUM_ACTIONS-1:0] sw_pulse_q;
  logic [NT-1:0]          sw_in_inh_q;
  logic [NT-1:0]          sw_out_inh_q;

  assign s_axi_awready = !aw_q && !bvalid_q;
  assign s_axi_wready  = !w_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  wire aw_take_w = s_axi_awvalid && s_axi_awready;
  wire w_take_w  = s_axi_wvalid && s_axi_wready;
  wire ar_take_w = s_axi_arvalid && s_axi_arready;
  wire wr_go_w   = aw_q && w_q;
  wire wr_ctrl_w = wr_go_w && awaddr_q == OFF_CTRL && wstrb0_q;
  wire wr_term_w = wr_go_w && awaddr_q == OFF_TERM && wstrb0_q;
  wire wr_ok_w   = awaddr_q == OFF_CTRL || awaddr_q == OFF_TERM
                   || awaddr_q == OFF_STATUS || awaddr_q == OFF_LOAD;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q  <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else begin
      if (aw_take_w) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take_w) begin
        w_q      <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_go_w) begin
        aw_q     <= 1'b0;
        w_q      <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok_w ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // software action pulses last one cycle; inhibits are sticky
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_pulse_q   <= CTRL_RESET[NUM_ACTIONS-1:0];
      sw_in_inh_q  <= TERM_RESET[NT-1:0];
      sw_out_inh_q <= TERM_RESET[2*NT-1:NT];
    end else begin
      sw_pulse_q <= wr_ctrl_w ? wdata_q[NUM_ACTIONS-1:0] : '0;
      if (wr_term_w) begin
        sw_in_inh_q  <= wdata_q[NT-1:0];
        sw_out_inh_q <= wdata_q[2*NT-1:NT];
      end
    end
  end

  // ---------------- panel pulses ----------------
  crl_pulse_if #(.N(NUM_ACTIONS)) pif ();
  assign pif.level = {storage_clear_switch, stop_switch, run_switch, load_switch,
                      system_reset_switch, second_selector_clear_switch,
                      first_selector_clear_switch, mux_channel_clear_switch};
  crl_edge_pulse #(.N(NUM_ACTIONS)) u_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pif     (pif)
  );
  wire [NUM_ACTIONS-1:0] act_w = pif.pulse | sw_pulse_q;
  wire sys_w  = act_w[CB_SYS_RST];

  // ---------------- resets ----------------
  logic mux_rst_q;
  logic sel1_rst_q;
  logic sel2_rst_q;
  logic sys_clr_q;
  logic stor_rst_q;
  logic reset_seen_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mux_rst_q  <= 1'b0;
      sel1_rst_q <= 1'b0;
      sel2_rst_q <= 1'b0;
      sys_clr_q  <= 1'b0;
      stor_rst_q <= 1'b0;
    end else begin
      mux_rst_q  <= act_w[CB_MUX_CLR] || sys_w;
      sel1_rst_q <= act_w[CB_SEL1_CLR] || sys_w;
      sel2_rst_q <= act_w[CB_SEL2_CLR] || sys_w;
      sys_clr_q  <= sys_w;
      stor_rst_q <= act_w[CB_STOR_CLR] || sys_w;
    end
  end
  assign mux_channel_reset     = mux_rst_q;
  assign sel1_channel_reset    = sel1_rst_q;
  assign sel2_channel_reset    = sel2_rst_q;
  assign system_clear          = sys_clr_q;
  assign storage_control_reset = stor_rst_q;

  // ---------------- initial load ----------------
  function automatic logic chan_valid(input logic [1:0] ch, input logic s1,
                                      input logic s2);
    unique case (ch)
      CHAN_MUX:  chan_valid = 1'b1;
      CHAN_SEL1: chan_valid = s1;
      CHAN_SEL2: chan_valid = s2;
      CHAN_BAD:  chan_valid = 1'b0;
    endcase
  endfunction
  wire chan_ok_w = chan_valid(load_channel_sw, sel1_installed, sel2_installed);
  logic       load_q;
  logic [1:0] ld_ch_q;
  logic [3:0] ld_cu_q;
  logic [3:0] ld_dev_q;
  logic [1:0] cc_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_q       <= 1'b0;
      ld_ch_q      <= CHAN_MUX;
      ld_cu_q      <= 4'h0;
      ld_dev_q     <= 4'h0;
      cc_q         <= COND_CODE_OK;
      reset_seen_q <= 1'b0;
    end else begin
      load_q <= 1'b0;
      if (sys_w) begin
        reset_seen_q <= 1'b1;
        cc_q         <= COND_CODE_OK;
      end else if (act_w[CB_LOAD]) begin
        if (!chan_ok_w) begin
          cc_q <= COND_CODE_BAD;
        end else if (reset_seen_q) begin
          load_q       <= 1'b1;
          reset_seen_q <= 1'b0;
          ld_ch_q      <= load_channel_sw;
          ld_cu_q      <= load_control_unit_sw;
          ld_dev_q     <= load_device_sw;
        end
      end
    end
  end
  assign load_start        = load_q;
  assign load_channel      = ld_ch_q;
  assign load_control_unit = ld_cu_q;
  assign load_device       = ld_dev_q;
  assign condition_code    = cc_q;

  // ---------------- run / stop ----------------
  crl_run_t run_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || sys_w) begin
      run_q <= CRL_IDLE;
    end else begin
      unique case (run_q)
        CRL_IDLE:     if (act_w[CB_RUN] || load_q) run_q <= CRL_RUNNING;
        CRL_RUNNING:  if (act_w[CB_STOP]) run_q <= instr_boundary ? CRL_IDLE : CRL_STOPPING;
        CRL_STOPPING: if (instr_boundary) run_q <= CRL_IDLE;
        default:      run_q <= CRL_IDLE;
      endcase
    end
  end
  assign processor_running = run_q != CRL_IDLE;
  assign io_enable = 1'b1;

  // ---------------- hold registers ----------------
  logic [7:0]  func_q;
  logic [15:0] addr_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      func_q <= 8'h00;
      addr_q <= 16'h0000;
    end else begin
      if (function_load && !instruction_hold_control) func_q <= function_next;
      if (address_load && !instruction_hold_control) addr_q <= address_next;
    end
  end
  assign function_register        = func_q;
  assign storage_address_register = addr_q;

  // ---------------- lamps ----------------
  logic pwr_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_q <= 1'b0;
    end else if (power_seq_done) begin
      pwr_q <= 1'b0;
    end else if (power_applied) begin
      pwr_q <= 1'b1;
    end
  end
  assign system_power_lamp = pwr_q;
  assign test_mode_lamp = switch_enable || power_fault_indicate || power_fault_off;

  // ---------------- line terminals ----------------
  wire [NT-1:0] in_inh_w  = term_in_inhibit | sw_in_inh_q;
  wire [NT-1:0] out_inh_w = term_out_inhibit | sw_out_inh_q;
  wire [NT-1:0] in_ok_w  = term_in_req & ~in_inh_w;
  wire [NT-1:0] out_ok_w = term_out_req & ~out_inh_w & ~(term_half_duplex & in_ok_w);
  // interleave so higher index wins, input above output
  logic [2*NT-1:0] req_w;
  logic [2*NT-1:0] gnt_w;
  always_comb begin
    gnt_w = '0;
    for (int i = 0; i < NT; i++) begin
      req_w[2*i]   = out_ok_w[i];
      req_w[2*i+1] = in_ok_w[i];
    end
    for (int j = 0; j < 2*NT; j++) begin
      if (req_w[j]) gnt_w = '0;
      if (req_w[j]) gnt_w[j] = 1'b1;
    end
  end
  logic [2*NT-1:0] gnt_q;
  logic [NT-1:0]   in_act_q;
  logic [NT-1:0]   out_act_q;
  logic [NT-1:0]   in_st_q;
  logic [NT-1:0]   out_st_q;
  logic            dial_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gnt_q     <= '0;
      in_act_q  <= '0;
      out_act_q <= '0;
      in_st_q   <= '0;
      out_st_q  <= '0;
      dial_q    <= 1'b0;
    end else begin
      gnt_q     <= gnt_w;
      in_act_q  <= in_ok_w;
      out_act_q <= out_ok_w;
      in_st_q   <= term_in_cmd & in_inh_w;
      out_st_q  <= term_out_cmd & out_inh_w;
      dial_q    <= !out_inh_w[0];
    end
  end
  assign term_grant            = gnt_q;
  assign term_in_active        = in_act_q;
  assign term_out_active       = out_act_q;
  assign term_in_status_valid  = in_st_q;
  assign term_out_status_valid = out_st_q;
  assign term_status_byte      = STATUS_EXC_BYTE;
  assign dialer_enable         = dial_q;

  // ---------------- read path ----------------
  wire [31:0] status_w = {24'h000000, pwr_q, test_mode_lamp, reset_seen_q,
                          instruction_hold_control, cc_q, run_q};
  wire [31:0] load_w   = {22'h000000, ld_ch_q, ld_cu_q, ld_dev_q};
  wire [31:0] term_w   = {{(32-2*NT){1'b0}}, sw_out_inh_q, sw_in_inh_q};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (ar_take_w) begin
      rvalid_q <= 1'b1;
      rresp_q  <= RESP_OKAY;
      unique case (s_axi_araddr)
        OFF_CTRL:   rdata_q <= 32'h0000_0000;
        OFF_STATUS: rdata_q <= status_w;
        OFF_LOAD:   rdata_q <= load_w;
        OFF_TERM:   rdata_q <= term_w;
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;
endmodule
`default_nettype wire

// ### testbench/crl_console_checker.sv
`timescale 1ns/100ps
`default_nettype none
module crl_console_checker
  import crl_pkg::*;
#(
  parameter int NT = 4
) (
  input wire logic          aclk,
  input wire logic          aresetn,
  input wire logic          switch_enable,
  input wire logic          power_fault_indicate,
  input wire logic          power_fault_off,
  input wire logic          instruction_hold_control,
  input wire logic [NT-1:0] term_half_duplex,
  input wire logic [NT-1:0] term_in_inhibit,
  input wire logic [NT-1:0] term_out_inhibit,
  input wire logic [NT-1:0] term_in_cmd,
  input wire logic          mux_channel_reset,
  input wire logic          sel1_channel_reset,
  input wire logic          sel2_channel_reset,
  input wire logic          system_clear,
  input wire logic          storage_control_reset,
  input wire logic          load_start,
  input wire logic [1:0]    load_channel,
  input wire logic          processor_running,
  input wire logic [7:0]    function_register,
  input wire logic [15:0]   storage_address_register,
  input wire logic          test_mode_lamp,
  input wire logic [NT-1:0] term_in_active,
  input wire logic [NT-1:0] term_out_active,
  input wire logic [2*NT-1:0] term_grant,
  input wire logic [NT-1:0] term_in_status_valid,
  input wire logic          dialer_enable
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_sys_all_clear:
  assert property (system_clear |-> mux_channel_reset && sel1_channel_reset
    && sel2_channel_reset && storage_control_reset) else $error("system clear incomplete");
  chk_clear_single:
  assert property (mux_channel_reset |=> !mux_channel_reset) else $error("clear pulse too long");
  chk_load_runs:
  assert property (load_start |=> !load_start && processor_running) else $error("load pulse bad");
  chk_lamp_test:
  assert property (test_mode_lamp == (switch_enable || power_fault_indicate || power_fault_off))
    else $error("test lamp wrong");
  chk_func_held:
  assert property (instruction_hold_control |=> $stable(function_register))
    else $error("function register moved under hold");
  chk_addr_held:
  assert property (instruction_hold_control |=> $stable(storage_address_register))
    else $error("address register moved under hold");
  chk_grant_onehot:
  assert property ($onehot0(term_grant)) else $error("grant not one-hot");
  chk_half_one:
  assert property ((term_in_active & term_out_active & $past(term_half_duplex)) == '0)
    else $error("half duplex pair both lit");
  chk_inhib_quiet:
  assert property (((term_in_active & $past(term_in_inhibit))
    | (term_out_active & $past(term_out_inhibit))) == '0) else $error("inhibited side active");
  chk_exc_answer:
  assert property ($past(aresetn) |-> ($past(term_in_cmd & term_in_inhibit)
    & ~term_in_status_valid) == '0) else $error("no status for inhibited command");
  chk_dialer_dead:
  assert property ($past(term_out_inhibit[0]) |-> !dialer_enable) else $error("dialer alive");
  chk_bad_no_load:
  assert property (load_start |-> load_channel != CHAN_BAD) else $error("bad channel loaded");
endmodule
bind crl_console crl_console_checker #(.NT(NT)) chk (.*);
`default_nettype wire

// ### testbench/crl_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
// instruction unit stand-in; long_instr stretches the current instruction
module crl_cpu_model (
  input  wire logic   aclk,
  input  wire logic   aresetn,
  input  wire logic   long_instr,
  output logic        instr_boundary,
  output logic        function_load,
  output logic [7:0]  function_next,
  output logic        address_load,
  output logic [15:0] address_next
);
  logic [7:0] seq_q;
  always @(posedge aclk) seq_q <= aresetn ? seq_q + 8'h01 : 8'h00;
  // loads carry fresh values each time so a missed hold shows up
  assign instr_boundary = !long_instr && seq_q[2:0] == 3'h6;
  assign function_load  = seq_q[1:0] == 2'h1;
  assign function_next  = seq_q ^ 8'hA5;
  assign address_load   = seq_q[1:0] == 2'h3;
  assign address_next   = {seq_q, ~seq_q};
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import crl_pkg::*;
  logic        aclk, aresetn, long_instr, bad, bnd;
  logic [7:0]  sw, function_next, function_register, term_grant, term_status_byte, f0;
  logic        mux_channel_clear_switch, first_selector_clear_switch, second_selector_clear_switch;
  logic        system_reset_switch, load_switch, run_switch, stop_switch, storage_clear_switch;
  logic        switch_enable, power_fault_indicate, power_fault_off, power_applied, power_seq_done;
  logic        instruction_hold_control, sel1_installed, sel2_installed;
  logic        instr_boundary, function_load, address_load, dialer_enable;
  logic        mux_channel_reset, sel1_channel_reset, sel2_channel_reset, system_clear;
  logic        storage_control_reset, load_start, processor_running, io_enable;
  logic        system_power_lamp, test_mode_lamp;
  logic [1:0]  load_channel_sw, load_channel, condition_code, s_axi_bresp, s_axi_rresp;
  logic [3:0]  load_control_unit_sw, load_device_sw, load_control_unit, load_device;
  logic [15:0] address_next, storage_address_register, a0;
  logic [3:0]  term_in_req, term_out_req, term_half_duplex, term_in_inhibit, term_out_inhibit;
  logic [3:0]  term_in_cmd, term_out_cmd, term_in_active, term_out_active, s_axi_wstrb;
  logic [3:0]  term_in_status_valid, term_out_status_valid, s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, exp;
  logic [5:0]  pv;
  int          err_total, cmp_count, pc[6], pc0[6];
  int          clr_bit[4] = '{0, 1, 2, 7};
  logic [5:0]  clr_exp[4] = '{6'h01, 6'h02, 6'h04, 6'h10};
  logic [11:0] pr_req[4] = '{12'hFF0, 12'h7F0, 12'h220, 12'h222};
  logic [15:0] pr_exp[4] = '{16'hFF80, 16'h7F40, 16'h2208, 16'h2008};
  logic [1:0]  ld_ch[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2};
  assign {storage_clear_switch, stop_switch, run_switch, load_switch, system_reset_switch,
    second_selector_clear_switch, first_selector_clear_switch, mux_channel_clear_switch} = sw;
  assign pv = {load_start, storage_control_reset, system_clear, sel2_channel_reset,
    sel1_channel_reset, mux_channel_reset};
  crl_console DUT (.*);
  crl_cpu_model cpu (.*);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // counting pulses catches both missing and doubled actions
  always @(posedge aclk) begin
    foreach (pc[i]) pc[i] += int'(pv[i]);
  end
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic press(input int b);
    pc0 = pc;
    sw[b] <= 1'b1;
    repeat (3) @(posedge aclk);
    sw[b] <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask
  task automatic pulses(input logic [5:0] e);
    foreach (pc[i]) check(32'(pc[i] - pc0[i]), 32'(e[i]));
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (!s_axi_bvalid);
    check(32'(s_axi_bresp), 32'(r));
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    check(s_axi_rdata, d);
    check(32'(s_axi_rresp), 32'(r));
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  initial begin
    {sw, long_instr, switch_enable, power_fault_indicate, power_fault_off, power_applied} = '0;
    {power_seq_done, instruction_hold_control, load_channel_sw, load_control_unit_sw} = '0;
    {load_device_sw, term_in_req, term_out_req, term_half_duplex, term_in_inhibit} = '0;
    {term_out_inhibit, term_in_cmd, term_out_cmd, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_wdata} = '0;
    {sel1_installed, sel2_installed, s_axi_wstrb} = '1;
    err_total = 0;
    cmp_count = 0;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    check(32'({io_enable, processor_running, condition_code, dialer_enable}), 32'h11);
    foreach (clr_bit[k]) begin
      press(clr_bit[k]);
      pulses(clr_exp[k]);
    end
    press(4);
    pulses(6'h00);
    press(3);
    pulses(6'h1F);
    check(32'({processor_running, condition_code}), 32'h0);
    for (int k = 0; k < 5; k++) begin
      load_channel_sw <= ld_ch[k];
      sel2_installed <= (k != 4);
      load_device_sw <= 4'(k + 9);
      load_control_unit_sw <= 4'h5;
      // a system reset always goes first
      press(3);
      press(4);
      bad = ld_ch[k] == CHAN_BAD || k == 4;
      pulses({!bad, 5'h00});
      check(32'(condition_code), 32'(bad ? COND_CODE_BAD : COND_CODE_OK));
      exp = bad ? 32'h0 : 32'({ld_ch[k], 4'h5, 4'(k + 9), 1'b1});
      if (!bad)
        check(32'({load_channel, load_control_unit, load_device, processor_running}), exp);
    end
    press(3);
    press(5);
    check(32'(processor_running), 32'h1);
    long_instr <= 1'b1;
    press(6);
    check(32'({processor_running, io_enable}), 32'h3);
    long_instr <= 1'b0;
    bnd = 1'b0;
    for (int n = 0; n < 20 && processor_running; n++) begin
      bnd = instr_boundary;
      @(posedge aclk);
    end
    check(32'({processor_running, bnd}), 32'h1);
    instruction_hold_control <= 1'b1;
    repeat (2) @(posedge aclk);
    f0 = function_register;
    a0 = storage_address_register;
    repeat (20) @(posedge aclk);
    check(32'({function_register, storage_address_register}), 32'({f0, a0}));
    instruction_hold_control <= 1'b0;
    repeat (10) @(posedge aclk);
    check(32'({function_register !== f0, storage_address_register !== a0}), 32'h3);
    power_applied <= 1'b1;
    repeat (2) @(posedge aclk);
    power_applied <= 1'b0;
    repeat (2) @(posedge aclk);
    check(32'(system_power_lamp), 32'h1);
    power_seq_done <= 1'b1;
    repeat (2) @(posedge aclk);
    check(32'(system_power_lamp), 32'h0);
    power_seq_done <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      {switch_enable, power_fault_indicate, power_fault_off} <= 3'(k);
      repeat (2) @(posedge aclk);
      check(32'(test_mode_lamp), 32'(k != 0));
    end
    for (int k = 0; k < 8; k++) begin
      term_in_req <= k[0] ? 4'(1 << (k / 2)) : 4'h0;
      term_out_req <= k[0] ? 4'h0 : 4'(1 << (k / 2));
      repeat (3) @(posedge aclk);
      check(32'({term_in_active, term_out_active, term_grant}),
        32'({term_in_req, term_out_req, 8'(1 << k)}));
    end
    foreach (pr_req[k]) begin
      {term_in_req, term_out_req, term_half_duplex} <= pr_req[k];
      repeat (3) @(posedge aclk);
      check(32'({term_in_active, term_out_active, term_grant}), 32'(pr_exp[k]));
    end
    {term_in_req, term_out_req, term_half_duplex} <= 12'h410;
    {term_in_inhibit, term_out_inhibit, term_in_cmd, term_out_cmd} <= 16'h4141;
    repeat (3) @(posedge aclk);
    exp = 32'({8'h00, 4'h4, 4'h1, STATUS_EXC_BYTE, 1'b0});
    check(32'({term_in_active, term_out_active, term_in_status_valid, term_out_status_valid,
      term_status_byte, dialer_enable}), exp);
    {term_in_inhibit, term_out_inhibit, term_in_cmd, term_out_cmd} <= 16'h0000;
    repeat (3) @(posedge aclk);
    check(32'({term_in_active, term_out_active, dialer_enable}), 32'h083);
    axi_wr(OFF_TERM, 32'h0000_0010, RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(32'(dialer_enable), 32'h0);
    axi_wr(OFF_TERM, 32'h0000_0000, RESP_OKAY);
    pc0 = pc;
    axi_wr(OFF_CTRL, 32'h0000_0002, RESP_OKAY);
    repeat (6) @(posedge aclk);
    pulses(6'h02);
    axi_rd(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
    axi_rd(OFF_LOAD, 32'h0000_025B, RESP_OKAY);
    axi_rd(OFF_STATUS, 32'h0000_0060, RESP_OKAY);
    axi_rd(4'h2, 32'h0000_0000, RESP_SLVERR);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
